// *** rtl/sp8_top.sv ***
// Eight-bit serial-to-parallel converter with word framing and bit slip.
// Assumes the serial clock and all control pins are asynchronous and much
// slower than the 125 MHz system clock; they are oversampled after two
// flops. Words are queued in a FIFO that software drains over AHB-Lite.
//
// Functional notes
// RULE_01 - Serial bits are gathered into eight-bit parallel words.
// RULE_02 - Mode pin high: capture on rising edges; low: on both edges.
// RULE_03 - An open mode pin reads low, giving dual-edge capture.
// RULE_04 - Input select picks primary or alternate data; low means primary.
// RULE_05 - Any unconnected pin reads as logic low.
// RULE_06 - The outside party pulses master reset before trusting output data.
// RULE_07 - Master reset stops the internal clock whatever the gate says.
// RULE_08 - After reset and one falling edge, capture starts on second rise.
// RULE_09 - Dual-edge mode: bit reaches outputs six clock cycles after capture.
// RULE_10 - Rising-only mode: bit reaches outputs twelve cycles after capture.
// RULE_11 - Dual-edge: slip held two cycles swallows the next edge.
// RULE_12 - Rising-only: slip held three cycles swallows the next rising edge.
// RULE_13 - One slip pulse shifts alignment one bit; more need more pulses.
// RULE_14 - Gate high one cycle stops the internal clock without runt pulses.
// RULE_15 - Gate changes take effect at a falling edge; restart on next rise.
// RULE_16 - Word clock is input clock over four (dual) or eight (rising).
// RULE_17 - Earliest bit of a word lands on output bit zero.
// RULE_18 - All eight outputs update together once per word with the frame.
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sp8_top #(
	parameter int FIFO_DEPTH = sp8_pkg::FIFO_DEPTH,
	localparam int LW = $clog2(FIFO_DEPTH) + 1
) (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        serial_clk,
	input  wire logic        serial_in_primary,
	input  wire logic        serial_in_alternate,
	input  wire logic        serial_input_select,
	input  wire logic        edge_mode_select,
	input  wire logic        clock_gate_n,
	input  wire logic        bit_slip,
	input  wire logic        master_reset,
	output logic [7:0]       parallel_out,
	output logic             word_clock,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ARM_WAIT_FALL,
		ARM_SKIP_RISE,
		ARM_WAIT_RISE,
		ARM_RUN
	} sp8_arm_e;

	typedef struct packed {
		sp8_arm_e    arm;
		logic        gate_on;
		logic        sclk_prev;
		logic [2:0]  slip_cnt;
		logic        slip_used;
		logic        swallow;
		logic [7:0]  word;
		logic [2:0]  bit_idx;
		logic [7:0]  pend;
		logic        pend_v;
		logic [2:0]  pend_cnt;
		logic [2:0]  phase;
		logic [7:0]  pout;
		logic        wclk;
		logic        push;
		logic        sw_en;
		logic [7:0]  a_addr;
		logic        a_wr;
		logic [31:0] rdata;
		logic        rdy;
		logic        resp;
	} sp8_state_s;

	localparam sp8_state_s RST = '{
		arm: ARM_WAIT_FALL, sw_en: sp8_pkg::CTRL_EN_RST, rdy: 1'b1,
		default: '0
	};

	if (FIFO_DEPTH < 2 || FIFO_DEPTH > (1 << 20)) begin : g_bad_depth
		$error("sp8_top: FIFO_DEPTH out of range");
	end

	sp8_state_s                    q;
	sp8_state_s                    d;
	logic [sp8_pkg::PIN_COUNT-1:0] pins;
	logic                          fifo_in_ready;
	logic                          fifo_out_valid;
	logic [7:0]                    fifo_out_data;
	logic [LW-1:0]                 fifo_level;
	logic                          fifo_pop;
	logic                          sclk;
	logic                          rise;
	logic                          fall;
	logic                          dual;
	logic                          din;
	logic                          mrst;
	logic                          run_ok;
	logic                          cap_edge;
	logic                          take_bit;
	logic                          emit;
	logic [2:0]                    slip_need;
	logic                          ahb_go;

	// ------------------------------------------------------------
	// Pin synchronisers and word FIFO
	// ------------------------------------------------------------
	sp8_sync #(
		.WIDTH (sp8_pkg::PIN_COUNT)
	) u_sync (
		.clock   (clock),
		.nrst    (nrst),
		.pin_in  ({master_reset, bit_slip, clock_gate_n, edge_mode_select,
			serial_input_select, serial_in_alternate, serial_in_primary,
			serial_clk}),
		.pin_out (pins)
	);

	sp8_fifo #(
		.WIDTH (sp8_pkg::WORD_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.nrst      (nrst),
		.in_valid  (q.push),
		.in_ready  (fifo_in_ready),
		.in_data   (q.pout),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data),
		.level     (fifo_level)
	);

	// ------------------------------------------------------------
	// Edge detection and input steering
	// ------------------------------------------------------------
	// Open pins read low: dual-edge mode, primary input (see RULE_03)
	assign sclk = pins[sp8_pkg::PIN_SCLK];
	assign rise = sclk & ~q.sclk_prev;
	assign fall = ~sclk & q.sclk_prev;
	assign dual = ~pins[sp8_pkg::PIN_MODE]; // see RULE_05
	assign din  = pins[sp8_pkg::PIN_SEL] ? pins[sp8_pkg::PIN_ALT]
		: pins[sp8_pkg::PIN_PRIM]; // see RULE_04
	assign mrst = pins[sp8_pkg::PIN_MRST];
	assign slip_need = dual ? sp8_pkg::SLIP_DUAL : sp8_pkg::SLIP_SINGLE;

	// Internal clock runs only when armed, gated on and FIFO has room.
	// A full FIFO halts capture rather than dropping a finished word.
	assign run_ok = ~mrst & q.gate_on & q.sw_en & fifo_in_ready
		& (q.arm == ARM_RUN || (q.arm == ARM_WAIT_RISE && rise)); // see RULE_07
	assign cap_edge = run_ok & (rise | (dual & fall)); // see RULE_02
	assign take_bit = cap_edge & ~q.swallow;
	assign emit     = take_bit & q.pend_v & (q.pend_cnt == 3'h1);

	// AHB-Lite address phase; reads of the data register pop a word
	assign ahb_go   = hsel & hready & htrans[1];
	assign fifo_pop = ahb_go & ~hwrite & (haddr[7:0] == sp8_pkg::ADDR_DATA);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		d           = q;
		d.push      = 1'b0;
		d.sclk_prev = sclk;

		// Gate sampled only at falling edges, so no partial pulses
		if (fall) begin
			d.gate_on = ~pins[sp8_pkg::PIN_GATEN]; // see RULE_14 see RULE_15
		end

		// Arming after master reset
		unique case (q.arm)
			ARM_WAIT_FALL: if (fall) d.arm = ARM_SKIP_RISE;
			ARM_SKIP_RISE: if (rise) d.arm = ARM_WAIT_RISE;
			ARM_WAIT_RISE: if (rise) d.arm = ARM_RUN; // see RULE_08
			ARM_RUN:       d.arm = ARM_RUN;
		endcase

		// Slip pulse width counted in input clock cycles
		if (rise) begin
			if (pins[sp8_pkg::PIN_SLIP]) begin
				if (q.slip_cnt != slip_need) begin
					d.slip_cnt = q.slip_cnt + 3'h1;
				end
				if (d.slip_cnt == slip_need && !q.slip_used) begin
					d.swallow   = 1'b1; // see RULE_11 see RULE_12
					d.slip_used = 1'b1; // see RULE_13
				end
			end else begin
				d.slip_cnt  = '0;
				d.slip_used = 1'b0;
			end
		end

		// Capture, with a swallowed edge moving the word start
		if (cap_edge && q.swallow) begin
			d.swallow = 1'b0;
		end
		if (take_bit) begin
			d.word[q.bit_idx] = din; // see RULE_17
			d.bit_idx         = q.bit_idx + 3'h1;
			if (q.pend_v) begin
				d.pend_cnt = q.pend_cnt - 3'h1;
			end
			if (emit) begin
				d.pout   = q.pend; // see RULE_18
				d.push   = 1'b1;
				d.pend_v = 1'b0;
				d.phase  = '0;
			end else begin
				d.phase = q.phase + 3'h1;
			end
			d.wclk = (d.phase < sp8_pkg::FRAME_HALF); // see RULE_16
			if (q.bit_idx == 3'h7) begin
				d.pend     = d.word; // see RULE_01
				d.pend_v   = 1'b1;
				d.pend_cnt = sp8_pkg::LAT_EDGES; // see RULE_09 see RULE_10
			end
		end

		// Master reset clears alignment; outputs hold their last word
		if (mrst) begin
			d.arm     = ARM_WAIT_FALL; // see RULE_06
			d.bit_idx = '0;
			d.pend_v  = 1'b0;
			d.phase   = '0;
			d.swallow = 1'b0;
		end

		// Bus slave: zero wait states, always OKAY
		d.rdy  = 1'b1;
		d.resp = 1'b0;
		if (q.a_wr && q.a_addr == sp8_pkg::ADDR_CTRL) begin
			d.sw_en = hwdata[sp8_pkg::CTRL_EN_BIT];
		end
		d.a_wr = ahb_go & hwrite;
		if (ahb_go) begin
			d.a_addr = haddr[7:0];
		end
		if (ahb_go && !hwrite) begin
			unique case (haddr[7:0])
				sp8_pkg::ADDR_CTRL:
					d.rdata = 32'(q.sw_en);
				sp8_pkg::ADDR_STAT:
					d.rdata = 32'({fifo_level, 4'h0, ~fifo_in_ready,
						~fifo_out_valid, dual,
						q.arm == ARM_RUN && q.gate_on});
				sp8_pkg::ADDR_DATA:
					d.rdata = 32'({fifo_out_valid, fifo_out_data});
				default:
					d.rdata = '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			q <= RST;
		end else begin
			q <= d;
		end
	end

	assign parallel_out = q.pout;
	assign word_clock   = q.wclk;
	assign hrdata       = q.rdata;
	assign hreadyout    = q.rdy;
	assign hresp        = q.resp;

	// ------------------------------------------------------------
	// Assertions and covers
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	// Watches the captured word, not the gating term that builds cap_edge
	chk_reset_halts_clk: assert property ( // see RULE_07
		mrst |=> !q.push && $stable(q.word))
		else $error("capture while master reset high");
	chk_gate_blocks_cap: assert property ( // see RULE_14
		!q.gate_on && !mrst
		|=> $stable(q.bit_idx) && $stable(q.word))
		else $error("capture while gated off");
	chk_rise_only_mode: assert property (cap_edge && !dual |-> rise) // see RULE_02
		else $error("non-rising capture in rising-only mode");
	chk_first_capture: assert property ( // see RULE_08
		cap_edge
		|-> q.arm == ARM_RUN || (q.arm == ARM_WAIT_RISE && rise))
		else $error("capture before arming finished");
	chk_frame_align: assert property ( // see RULE_18
		q.push
		|-> q.wclk && q.phase == 3'h0 && $past(q.pend) == q.pout)
		else $error("word not aligned to frame");
	chk_slip_width: assert property ( // see RULE_11
		$rose(q.swallow) |-> q.slip_cnt == slip_need && q.slip_used)
		else $error("slip swallowed with wrong pulse width");
	chk_swallow_once: assert property ( // see RULE_13
		cap_edge && q.swallow |=> !q.swallow && $stable(q.bit_idx))
		else $error("swallow did not drop exactly one edge");
	chk_latency_emit: assert property ( // see RULE_09
		take_bit && q.pend_v && q.pend_cnt == 3'h1
		|=> q.push ##1 !q.push)
		else $error("word not emitted at end of latency");
	chk_push_room: assert property (q.push |-> fifo_in_ready) // no push while the FIFO is full; run_ok halts capture instead
		else $error("push into full FIFO");

	cov_slip: cover property ($rose(q.swallow));
	cov_dual_word: cover property (q.push && dual);
	cov_rise_word: cover property (q.push && !dual);
	cov_fifo_full: cover property (!fifo_in_ready);
endmodule : sp8_top
`default_nettype wire

// *** pkg/sp8_pkg.sv ***
// Shared constants of the eight-bit serial-to-parallel converter.
// Assumes a 125 MHz system clock and 32-bit AHB-Lite register access.
package sp8_pkg;
	// ------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ------------------------------------------------------------
	localparam logic [7:0]  ADDR_CTRL    = 8'h00;
	localparam logic [7:0]  ADDR_STAT    = 8'h04;
	localparam logic [7:0]  ADDR_DATA    = 8'h08;
	localparam int          CTRL_EN_BIT  = 0;
	localparam logic        CTRL_EN_RST  = 1'h1;
	localparam int          STAT_LVL_LSB = 8;
	localparam int          DATA_VLD_BIT = 8;

	// ------------------------------------------------------------
	// Pin synchroniser lanes
	// ------------------------------------------------------------
	localparam int PIN_SCLK  = 0;
	localparam int PIN_PRIM  = 1;
	localparam int PIN_ALT   = 2;
	localparam int PIN_SEL   = 3;
	localparam int PIN_MODE  = 4;
	localparam int PIN_GATEN = 5;
	localparam int PIN_SLIP  = 6;
	localparam int PIN_MRST  = 7;
	localparam int PIN_COUNT = 8;

	// ------------------------------------------------------------
	// Conversion counts
	// ------------------------------------------------------------
	localparam int         WORD_BITS   = 8;
	localparam logic [2:0] SLIP_DUAL   = 3'h2; // Cycles of slip, dual edge
	localparam logic [2:0] SLIP_SINGLE = 3'h3; // Cycles of slip, rising only
	localparam logic [2:0] LAT_EDGES   = 3'h5; // Edges from word end to output
	localparam logic [2:0] FRAME_HALF  = 3'h4; // Capture edges per half frame
	localparam int         FIFO_DEPTH  = 32;
endpackage : sp8_pkg

// *** rtl/sp8_sync.sv ***
// Two-flop synchroniser for a group of independent pin levels.
// Assumes each lane is a slow level; lanes are not coherent with each other.
`timescale 1ns/1ps
`default_nettype none
module sp8_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clock,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_out
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sp8_sync_s;

	sp8_sync_s q;
	sp8_sync_s d;

	// ------------------------------------------------------------
	// Stages: the first stage feeds only the second
	// ------------------------------------------------------------
	always_comb begin
		d.s1 = pin_in;
		d.s2 = q.s1;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pin_out = q.s2;
endmodule : sp8_sync
`default_nettype wire

// *** rtl/sp8_fifo.sv ***
// Word FIFO in flip-flops with valid/ready on both sides.
// Assumes a power-of-two depth; push and pop may share a cycle.
`timescale 1ns/1ps
`default_nettype none
module sp8_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32,
	localparam int AW = $clog2(DEPTH)
) (
	input  wire logic          clock,
	input  wire logic          nrst,
	input  wire logic          in_valid,
	output logic               in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic               out_valid,
	input  wire logic          out_ready,
	output logic [WIDTH-1:0]   out_data,
	output logic [AW:0]        level
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} sp8_fifo_s;

	sp8_fifo_s q;
	sp8_fifo_s d;
	logic      push;
	logic      pop;

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("sp8_fifo: DEPTH must be a power of two, at least 2");
	end

	// ------------------------------------------------------------
	// Pointers wrap naturally because depth is a power of two
	// ------------------------------------------------------------
	assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (q.cnt != '0);
	assign out_data  = q.mem[q.rp];
	assign level     = q.cnt;
	assign push      = in_valid & in_ready;
	assign pop       = out_ready & out_valid;

	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wp] = in_data;
			d.wp        = q.wp + 1'b1;
		end
		if (pop) begin
			d.rp = q.rp + 1'b1;
		end
		d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : sp8_fifo
`default_nettype wire

// *** sim/sp8_src.sv ***
// Serial source model: drives the serial clock and both data lanes.
// Assumes the system clock is much faster than the serial clock.
`timescale 1ns/1ps
`default_nettype none
module sp8_src (
	input  wire logic clock,
	output logic      serial_clk,
	output logic      serial_in_primary,
	output logic      serial_in_alternate
);
	// ------------------------------------------------------------
	// Idle state
	// ------------------------------------------------------------
	// Clock stands low outside frames; lanes start opposite
	initial begin
		serial_clk          = 1'h0;
		serial_in_primary   = 1'h0;
		serial_in_alternate = 1'h1;
	end

	// ------------------------------------------------------------
	// Bit sender
	// ------------------------------------------------------------
	// One clock toggle per bit in dual mode, a full pulse when rising
	// only; data settles four cycles either side of the capture edge
	task automatic send(input logic [63:0] bits, input int n,
			input logic alt, input logic rise_only);
		for (int i = 0; i < n; i++) begin
			@(posedge clock);
			serial_in_primary   <= alt ? ~bits[i] : bits[i];
			serial_in_alternate <= alt ? bits[i] : ~bits[i];
			repeat (4) @(posedge clock);
			serial_clk <= ~serial_clk;
			repeat (4) @(posedge clock);
			if (rise_only) begin
				serial_clk <= 1'h0;
				repeat (4) @(posedge clock);
			end
		end
		// Released lanes flip so a stale bit is never mistaken for data
		serial_in_primary   <= ~serial_in_primary;
		serial_in_alternate <= ~serial_in_alternate;
	endtask : send
endmodule : sp8_src
`default_nettype wire

// *** sim/tb_sp8_top.sv ***
// Testbench of the serial-to-parallel converter with its FIFO and bus.
// Assumes the serial source model and a four-word FIFO in the design.
`timescale 1ns/1ps
`default_nettype none
module tb_sp8_top;
	logic        clock;
	logic        nrst;
	logic        serial_input_select;
	logic        edge_mode_select;
	logic        clock_gate_n;
	logic        bit_slip;
	logic        master_reset;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	wire  logic        serial_clk;
	wire  logic        sin_p;
	wire  logic        sin_a;
	wire  logic [7:0]  parallel_out;
	wire  logic        word_clock;
	wire  logic [31:0] hrdata;
	wire  logic        hreadyout;
	wire  logic        hresp;
	int          miscompares;
	int          checks_done;
	int          cycles;
	logic [31:0] rd;
	logic [7:0]  pats [4] = '{8'h96, 8'h2d, 8'he1, 8'h4b};

	sp8_top #(.FIFO_DEPTH(4)) i_sp8_top (
		.clock(clock), .nrst(nrst), .serial_clk(serial_clk),
		.serial_in_primary(sin_p), .serial_in_alternate(sin_a),
		.serial_input_select(serial_input_select),
		.edge_mode_select(edge_mode_select), .clock_gate_n(clock_gate_n),
		.bit_slip(bit_slip), .master_reset(master_reset),
		.parallel_out(parallel_out), .word_clock(word_clock),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp)
	);

	sp8_src i_sp8_src (
		.clock(clock), .serial_clk(serial_clk),
		.serial_in_primary(sin_p), .serial_in_alternate(sin_a)
	);

	// ------------------------------------------------------------
	// Clock, timeout and verdict
	// ------------------------------------------------------------
	// 125 MHz system clock
	initial begin
		clock = 1'h0;
		forever #4 clock = ~clock;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	// Whole run needs some 3000 cycles; the ceiling leaves wide margin
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			finish_test();
		end
	end

	// ------------------------------------------------------------
	// Compare and bus tasks
	// ------------------------------------------------------------
	task automatic chk_word(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_word

	task automatic chk_pin(input string what, input logic [7:0] exp,
			input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_pin

	// Single word read; data taken at the edge that ends the data phase
	task automatic ahb_rd(input logic [7:0] a, output logic [31:0] d);
		hsel   <= 1'h1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= 1'h0;
		hsize  <= 3'h2;
		do @(posedge clock); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		do @(posedge clock); while (hreadyout !== 1'h1);
		d = hrdata;
		chk_pin("hresp", 8'h0, {7'h0, hresp});
	endtask : ahb_rd

	task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'h1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= 1'h1;
		hsize  <= 3'h2;
		do @(posedge clock); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'h1);
	endtask : ahb_wr

	// ------------------------------------------------------------
	// Serial sequences
	// ------------------------------------------------------------
	// Select lane and mode, pulse master reset with edges it must ignore,
	// then the two-pulse preamble before the first captured rise; slip
	// raised after reset release so the reset cannot use up the pulse
	task automatic arm(input logic alt, input logic rise,
			input logic slip);
		serial_input_select <= alt;
		edge_mode_select    <= rise;
		master_reset        <= 1'h1;
		i_sp8_src.send(64'h5a, 8, alt, rise);
		master_reset <= 1'h0;
		repeat (8) @(posedge clock);
		bit_slip <= slip;
		i_sp8_src.send(64'h0, rise ? 2 : 4, alt, rise);
	endtask : arm

	// One word, checked one edge short of its latency and at it
	task automatic run_word(input logic [7:0] b, input logic alt,
			input logic rise, input logic en);
		arm(alt, rise, 1'h0);
		ahb_rd(sp8_pkg::ADDR_STAT, rd);
		chk_word("stat mode", {30'h0, ~rise, 1'h0}, rd & 32'h2);
		i_sp8_src.send({52'h0, 4'h9, b}, 12, alt, rise);
		repeat (8) @(posedge clock);
		ahb_rd(sp8_pkg::ADDR_DATA, rd);
		chk_word("data early", 32'h0, rd & 32'h100);
		i_sp8_src.send(64'h1, 1, alt, rise);
		repeat (8) @(posedge clock);
		if (en) begin
			chk_pin("parallel_out", b, parallel_out);
			chk_pin("word_clock hi", 8'h1, {7'h0, word_clock});
		end
		ahb_rd(sp8_pkg::ADDR_DATA, rd);
		chk_word("data word", en ? {23'h0, 1'h1, b} : 32'h0,
			en ? rd : (rd & 32'h100));
		i_sp8_src.send(64'h0, 7, alt, rise);
		repeat (8) @(posedge clock);
		if (en)
			chk_pin("word_clock lo", 8'h0, {7'h0, word_clock});
	endtask : run_word

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		nrst = 1'h0;
		serial_input_select = 1'h0;
		edge_mode_select = 1'h0;
		clock_gate_n = 1'h0;
		bit_slip = 1'h0;
		master_reset = 1'h0;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		miscompares = 0;
		checks_done = 0;
		cycles = 0;
		repeat (8) @(posedge clock);
		chk_pin("reset out", 8'h0, parallel_out);
		chk_pin("reset frame", 8'h0, {7'h0, word_clock});
		nrst <= 1'h1;
		@(posedge clock);
		// Reset values, then an unmapped place that must stay zero
		ahb_rd(sp8_pkg::ADDR_CTRL, rd);
		chk_word("ctrl reset", 32'h1, rd);
		ahb_rd(sp8_pkg::ADDR_STAT, rd);
		chk_word("stat reset", 32'h6, rd & 32'h3f0e);
		ahb_wr(8'h0c, 32'hffffffff);
		ahb_rd(8'h0c, rd);
		chk_word("unmapped", 32'h0, rd);
		// Every lane and mode combination
		for (int k = 0; k < 4; k++)
			run_word(pats[k], k[0], k[1], 1'h1);
		// Capture disabled by software: nothing may reach the FIFO
		ahb_wr(sp8_pkg::ADDR_CTRL, 32'h0);
		ahb_rd(sp8_pkg::ADDR_CTRL, rd);
		chk_word("ctrl off", 32'h0, rd);
		run_word(8'h77, 1'h0, 1'h0, 1'h0);
		ahb_wr(sp8_pkg::ADDR_CTRL, 32'h1);
		// Six words into a four-word FIFO with the reader stalled
		arm(1'h0, 1'h0, 1'h0);
		i_sp8_src.send({10'h0, 48'h5f4e3d2c1b0a}, 54, 1'h0, 1'h0);
		repeat (8) @(posedge clock);
		ahb_rd(sp8_pkg::ADDR_STAT, rd);
		chk_word("stat full", 32'h40a, rd & 32'h3f0e);
		for (int k = 0; k < 4; k++) begin
			ahb_rd(sp8_pkg::ADDR_DATA, rd);
			chk_word("drain", {23'h0, 1'h1, 4'(k), 4'(k + 10)},
				rd);
		end
		ahb_rd(sp8_pkg::ADDR_STAT, rd);
		chk_word("stat empty", 32'h6, rd & 32'h3f0e);
		// Slip held two rises in the preamble drops the first stream bit
		arm(1'h0, 1'h0, 1'h1);
		bit_slip <= 1'h0;
		i_sp8_src.send({55'h0, 8'h5b, 1'h1}, 14, 1'h0, 1'h0);
		repeat (8) @(posedge clock);
		chk_pin("slip out", 8'h5b, parallel_out);
		ahb_rd(sp8_pkg::ADDR_DATA, rd);
		chk_word("slip word", 32'h15b, rd);
		// Gated edges are ignored; after release a fall re-enables and
		// the following rise takes the first bit
		clock_gate_n <= 1'h1;
		arm(1'h0, 1'h0, 1'h0);
		i_sp8_src.send(64'hf, 4, 1'h0, 1'h0);
		clock_gate_n <= 1'h0;
		i_sp8_src.send({54'h0, 8'hc6, 2'h3}, 16, 1'h0, 1'h0);
		repeat (8) @(posedge clock);
		chk_pin("gate out", 8'hc6, parallel_out);
		ahb_rd(sp8_pkg::ADDR_DATA, rd);
		chk_word("gate word", 32'h1c6, rd);
		finish_test();
	end
endmodule : tb_sp8_top
`default_nettype wire
